// *** dv/od_host_model.sv ***
// Host model: register accesses on the strobe bus
`timescale 1ns/100ps
module od_host_model (
  input wire logic ref_clk,                     // Clock
  input wire logic [7:0] reg_rdata,             // Read data
  output logic reg_wr,                          // Write strobe
  output logic reg_rd,                          // Read strobe
  output logic [od_pkg::OD_AW-1:0] reg_addr,    // Address
  output logic [7:0] reg_wdata                  // Write data
);
  import od_pkg::*;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [OD_AW-1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [OD_AW-1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    #1 d = reg_rdata;
  endtask
endmodule

// *** dv/od_orientation_detector_tb.sv ***
// Self-checking bench of the orientation detector
`timescale 1ns/100ps
module od_orientation_detector_tb;
  import od_pkg::*;
  logic ref_clk, rst, standby, sample_valid, reg_wr, reg_rd, orient_irq;
  od_sample_s sample;
  logic [OD_AW-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, output_rate_control, rd_v;
  od_status_s orient_status;
  int n_errors = 0, check_count = 0, n_irq = 0, cycles = 0;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  od_orientation_detector dut_u (.ref_clk(ref_clk), .rst(rst), .standby(standby), .sample_valid(sample_valid),
    .sample(sample), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .output_rate_control(output_rate_control), .orient_status(orient_status),
    .orient_irq(orient_irq));
  od_host_model host_u (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  // ----------------------------------------------------------------
  // Event counter and hang guard
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (orient_irq === 1'b1) n_irq <= n_irq + 1;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stat(input string what, input logic [7:0] exp);
    host_u.rd(OD_ADDR_STAT, rd_v);
    check(what, rd_v, exp);
  endtask

  task automatic feed(input logic signed [15:0] x, y, z, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      sample_valid <= 1'b1;
      sample <= '{x: x, y: y, z: z};
      @(posedge ref_clk);
      sample_valid <= 1'b0;
    end
    repeat (3) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    standby = 1'b0;
    sample_valid = 1'b0;
    sample = '0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    host_u.rd(OD_ADDR_RATE, rd_v);
    check("rate reset", rd_v, OD_RATE_RST);
    host_u.rd(OD_ADDR_CONF, rd_v);
    check("conf reset", rd_v, OD_CONF_RST);
    host_u.rd(6'h00, rd_v);
    check("unmapped", rd_v, 8'h00);
    host_u.wr(OD_ADDR_STAT, 8'hFF);
    stat("status read only", 8'h00);
    host_u.wr(OD_ADDR_CONF, 8'h80);
    feed(256, 0, 0, 20);
    stat("portrait up", 8'h48);
    check("no event at default", 8'(n_irq), 8'h00);
    feed(0, -256, 0, 20);
    stat("landscape down", 8'h7B);
    check("2d event", 8'(n_irq), 8'h01);
    host_u.wr(OD_ADDR_CONF, 8'h88);
    feed(0, 0, 256, 20);
    host_u.rd(OD_ADDR_STAT, rd_v);
    check("top face", {4'h0, rd_v[3:0]}, 8'h0C);
    check("3d event", 8'(n_irq), 8'h02);
    host_u.wr(OD_ADDR_RATE, 8'h0B);
    stat("cleared by rate write", 8'h00);
    check("rate output", output_rate_control, 8'h0B);
    feed(0, 0, 256, 1);
    check("event from undefined", 8'(n_irq), 8'h03);
    host_u.wr(OD_ADDR_CONF, 8'h80);
    @(posedge ref_clk);
    standby <= 1'b1;
    @(posedge ref_clk);
    standby <= 1'b0;
    @(negedge ref_clk);
    check("cleared by standby", orient_status, 8'h00);
    feed(256, 0, 0, 1);
    check("no event at plus x", 8'(n_irq), 8'h03);
    host_u.wr(OD_ADDR_CONF, 8'hA0);
    feed(256, 230, 0, 20);
    host_u.rd(OD_ADDR_STAT, rd_v);
    check("dead zone flags", {6'h00, rd_v[6], rd_v[3]}, 8'h00);
    host_u.wr(OD_ADDR_CONF, 8'h80);
    feed(256, 230, 0, 2);
    stat("narrow zone valid", 8'h48);
    host_u.wr(OD_ADDR_CONF, 8'h03);
    feed(0, -256, 0, 4);
    host_u.rd(OD_ADDR_STAT, rd_v);
    check("slow filter holds", {5'h00, rd_v[6:4]}, 8'h04);
    feed(0, -256, 0, 60);
    host_u.rd(OD_ADDR_STAT, rd_v);
    check("slow filter settles", {5'h00, rd_v[6:4]}, 8'h07);
    tally_and_finish();
  end
endmodule

// *** verilog/od_orientation_detector.sv ***
// Orientation detector: filter, 2D/3D classification, registers and event
`timescale 1ns/100ps

// Operation
// - Orientation status register holds 2D and 3D results together.
// - Status bit 6 flags 2D validity, bit 3 flags 3D validity.
// - Cleared flag means orientation unknown, including dead zone.
// - 2D uses x and y; portrait from x sign, landscape from y sign.
// - 3D adds z; reports which of six faces is up, by axis and sign.
// - Samples low-pass filtered; bandwidth from config bits 2:0.
// - Filter uses output samples; status updates once per sample.
// - Bandwidth is fraction of data rate; code 3 gives rate/100.
// - Config bits 6:4 set dead zone width.
// - Dead zone angle is total, split evenly about the bisector.
// - Config bit 7 enables event on new valid orientation.
// - Config bit 3 selects whether 2D or 3D drives the event.
// - Rate register write or standby clears filter and status.
// - After clearing, event only if orientation differs from +X or undefined.
module od_orientation_detector #(
  parameter int unsigned DW = 16
) (
  input wire logic ref_clk,                    // 100 MHz clock
  input wire logic rst,                        // Async reset, active high
  input wire logic standby,                    // Part in standby
  input wire logic sample_valid,               // New output sample
  input wire od_pkg::od_sample_s sample,       // Output acceleration sample
  input wire logic reg_wr,                     // Register write strobe
  input wire logic reg_rd,                     // Register read strobe
  input wire logic [od_pkg::OD_AW-1:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata,            // Write data
  output logic [7:0] reg_rdata,                // Read data, one cycle after strobe
  output logic [7:0] output_rate_control,      // Rate register contents
  output od_pkg::od_status_s orient_status,    // Orientation status register
  output logic orient_irq                      // One-cycle new orientation event
);
  import od_pkg::*;

  localparam int unsigned FW = DW + OD_FRAC;

  // ----------------------------------------------------------------
  // Registers and function reset
  // ----------------------------------------------------------------
  logic [7:0] rate_r;
  logic [7:0] conf_r;
  logic [7:0] rdata_r;
  od_status_s stat_r;
  logic pend_r;
  logic irq_r;
  logic [2:0] last2_r;
  logic [2:0] last3_r;

  wire wr_rate = reg_wr && (reg_addr == OD_ADDR_RATE);
  wire wr_conf = reg_wr && (reg_addr == OD_ADDR_CONF);
  wire fn_rst = wr_rate || standby;
  wire irq_en = conf_r[OD_CONF_IRQ_EN];
  wire sel3d = conf_r[OD_CONF_SEL3D];
  wire [2:0] div_code = conf_r[OD_CONF_DIV_HI:OD_CONF_DIV_LO];
  wire [2:0] dz_code = conf_r[OD_CONF_DZ_HI:OD_CONF_DZ_LO];

  logic [7:0] rd_val;
  assign rd_val = (reg_addr == OD_ADDR_RATE) ? rate_r :
                  (reg_addr == OD_ADDR_CONF) ? conf_r :
                  (reg_addr == OD_ADDR_STAT) ? stat_r : OD_ZERO8;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rate_r <= OD_RATE_RST;
      conf_r <= OD_CONF_RST;
      rdata_r <= OD_ZERO8;
    end else begin
      if (wr_rate) begin
        rate_r <= reg_wdata;
      end
      if (wr_conf) begin
        conf_r <= reg_wdata;
      end
      if (reg_rd) begin
        rdata_r <= rd_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Low-pass filter, one per axis
  // ----------------------------------------------------------------
  logic signed [DW-1:0] raw [3];
  logic signed [FW-1:0] filt_r [3];
  logic [DW-1:0] mag [3];
  logic neg [3];
  // Shift of first-order filter; code 3 gives 1/16, about rate/100
  wire [3:0] shift = {1'b0, div_code} + OD_SHIFT_BASE;

  assign raw[0] = sample.x;
  assign raw[1] = sample.y;
  assign raw[2] = sample.z;

  for (genvar i = 0; i < 3; i++) begin : g_axis
    wire signed [FW:0] diff = {raw[i][DW-1], raw[i], {OD_FRAC{1'b0}}} - {filt_r[i][FW-1], filt_r[i]};
    wire signed [FW:0] step = diff >>> shift;
    wire signed [DW-1:0] whole = filt_r[i][FW-1:OD_FRAC];
    assign neg[i] = whole[DW-1];
    assign mag[i] = neg[i] ? DW'(-whole) : DW'(whole);

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        filt_r[i] <= '0;
      end else if (fn_rst) begin
        filt_r[i] <= '0;
      end else if (sample_valid) begin
        filt_r[i] <= filt_r[i] + step[FW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  // Valid only if second/largest ratio stays below the zone limit
  wire [7:0] dz_ratio = OD_DZ_RATIO[dz_code];

  wire x_over_y = mag[0] >= mag[1];
  wire [DW-1:0] a2 = x_over_y ? mag[0] : mag[1];
  wire [DW-1:0] b2 = x_over_y ? mag[1] : mag[0];
  wire [1:0] code2 = x_over_y ? {1'b0, neg[0]} : {1'b1, neg[1]};
  wire valid2 = ({b2, 8'h00} < (a2 * dz_ratio)) && (a2 != '0);

  wire [1:0] big3 = (x_over_y && mag[0] >= mag[2]) ? 2'h0 :
                    (!x_over_y && mag[1] >= mag[2]) ? 2'h1 : 2'h2;
  wire [DW-1:0] a3 = mag[big3];
  wire [DW-1:0] b3 = (big3 == 2'h2) ? a2 : ((mag[2] > b2) ? mag[2] : b2);
  wire [2:0] code3 = {big3, neg[big3]};
  wire valid3 = ({b3, 8'h00} < (a3 * dz_ratio)) && (a3 != '0);

  od_status_s cls;
  assign cls = '{rsvd: 1'b0, valid_2d_flag: valid2, code_2d: code2, valid_3d_flag: valid3, code_3d: code3};

  // ----------------------------------------------------------------
  // Status, event tracking
  // ----------------------------------------------------------------
  wire new2 = valid2 && ({1'b0, code2} != last2_r);
  wire new3 = valid3 && (code3 != last3_r);
  wire fire = pend_r && irq_en && (sel3d ? new3 : new2);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b0;
      stat_r <= '0;
      irq_r <= 1'b0;
      last2_r <= OD_2D_LAST_RST;
      last3_r <= OD_3D_LAST_RST;
    end else if (fn_rst) begin
      pend_r <= 1'b0;
      stat_r <= '0;
      irq_r <= 1'b0;
      last2_r <= OD_2D_LAST_RST;
      last3_r <= OD_3D_LAST_RST;
    end else begin
      pend_r <= sample_valid;
      irq_r <= fire;
      if (pend_r) begin
        stat_r <= cls;
        if (valid2) begin
          last2_r <= {1'b0, code2};
        end
        if (valid3) begin
          last3_r <= code3;
        end
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign output_rate_control = rate_r;
  assign orient_status = stat_r;
  assign orient_irq = irq_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_fresh_start;
    fn_rst ##1 !fn_rst ##1 (!fn_rst && !pend_r);
  endsequence

  sequence s_sample_taken;
    sample_valid && !fn_rst ##1 !fn_rst;
  endsequence

  chk_status_clear: assert property (fn_rst |=> stat_r == '0 && !irq_r && !pend_r)
    else $error("status not cleared by function reset");
  chk_filter_clear: assert property (fn_rst |=> filt_r[0] == '0 && filt_r[1] == '0 && filt_r[2] == '0)
    else $error("filter not cleared by function reset");
  chk_status_per_sample: assert property (s_sample_taken |=> stat_r == $past(cls))
    else $error("status not updated one cycle after sample");
  chk_status_hold: assert property (!pend_r && !fn_rst |=> $stable(stat_r))
    else $error("status changed without a sample");
  chk_irq_enable: assert property (orient_irq |-> $past(irq_en, 2) || $past(irq_en))
    else $error("event raised while disabled");
  chk_irq_mode_flag: assert property (orient_irq |-> ($past(sel3d) ? stat_r.valid_3d_flag : stat_r.valid_2d_flag))
    else $error("event from unselected or invalid mode");
  // First classification after a function reset, last 2D code still at default
  chk_default_2d: assert property (s_fresh_start ##1 (!fn_rst && pend_r && !sel3d)
    ##0 (valid2 && code2 == OD_2D_PLUS_X) |=> !orient_irq)
    else $error("event for default 2D orientation");
  chk_div3_step: assert property (sample_valid && !fn_rst && div_code == 3'h3 |=>
    filt_r[0] == $past(filt_r[0] + FW'(($signed({raw[0][DW-1], raw[0], {OD_FRAC{1'b0}}})
    - $signed({filt_r[0][FW-1], filt_r[0]})) >>> 4)))
    else $error("filter step for divisor 3 wrong");
  chk_rate_write: assert property (wr_rate |=> rate_r == $past(reg_wdata) && stat_r == '0)
    else $error("rate write not stored or not resetting");
  // Equal magnitudes sit on the bisector, invalid for every zone width
  chk_dead_zone: assert property (pend_r && !fn_rst && mag[0] == mag[1] |=> !stat_r.valid_2d_flag)
    else $error("dead zone reported as valid");
  chk_status_read: assert property (reg_rd && reg_addr == OD_ADDR_STAT |=> reg_rdata == $past(orient_status))
    else $error("status read back wrong");

endmodule

// *** verilog/od_pkg.sv ***
// Constants, codes and carriers of the orientation detector
package od_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned OD_AW = 6;
  localparam logic [OD_AW-1:0] OD_ADDR_RATE = 6'h2C;
  localparam logic [OD_AW-1:0] OD_ADDR_CONF = 6'h3B;
  localparam logic [OD_AW-1:0] OD_ADDR_STAT = 6'h3C;
  localparam logic [7:0] OD_RATE_RST = 8'h0A;
  localparam logic [7:0] OD_CONF_RST = 8'h00;
  localparam logic [7:0] OD_ZERO8 = 8'h00;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  localparam int unsigned OD_CONF_IRQ_EN = 7;
  localparam int unsigned OD_CONF_DZ_HI = 6;
  localparam int unsigned OD_CONF_DZ_LO = 4;
  localparam int unsigned OD_CONF_SEL3D = 3;
  localparam int unsigned OD_CONF_DIV_HI = 2;
  localparam int unsigned OD_CONF_DIV_LO = 0;

  // ----------------------------------------------------------------
  // Orientation codes: {axis index, negative}
  // ----------------------------------------------------------------
  localparam logic [1:0] OD_2D_PLUS_X = 2'h0;
  localparam logic [2:0] OD_3D_FRONT = 3'h0;
  localparam logic [2:0] OD_3D_LEFT = 3'h2;
  localparam logic [2:0] OD_3D_TOP = 3'h4;
  localparam logic [2:0] OD_3D_BOTTOM = 3'h5;
  localparam logic [2:0] OD_2D_LAST_RST = 3'h0;
  localparam logic [2:0] OD_3D_LAST_RST = 3'h7;

  // ----------------------------------------------------------------
  // Filter and dead zone
  // ----------------------------------------------------------------
  localparam int unsigned OD_FRAC = 8;
  localparam logic [3:0] OD_SHIFT_BASE = 4'h1;
  localparam logic [7:0] OD_DZ_UNITY = 8'hFF;
  // Ratio limit tan(45deg - half zone) in 1/256, total zone 5.1deg per step
  localparam logic [7:0] OD_DZ_RATIO [8] = '{8'hFF, 8'hEA, 8'hD6, 8'hC3, 8'hB2, 8'hA1, 8'h92, 8'h83};

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } od_sample_s;

  typedef struct packed {
    logic rsvd;
    logic valid_2d_flag;
    logic [1:0] code_2d;
    logic valid_3d_flag;
    logic [2:0] code_3d;
  } od_status_s;

endpackage
